//--- include/serial_port_regs.vh
// serial port control register constants and timing counts
// assumes a 40 MHz peripheral clock and a plain register port
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_CONTROL   8'h98
`define ADDR_DATA      8'h99
`define ADDR_RELOAD    8'h9A
`define ADDR_RATECTL   8'h9B
`define ADDR_IRQ_STAT  8'hA0
`define ADDR_IRQ_MASK  8'hA1
// ----------------------------------------
// control field positions
// ----------------------------------------
`define BIT_MODE_HI    7
`define BIT_MODE_LO    6
`define BIT_MPCE       5
`define BIT_RX_EN      4
`define BIT_TX9        3
`define BIT_RX9        2
`define BIT_TXDONE     1
`define BIT_RXDONE     0
`define BIT_DOUBLE     0
`define CONTROL_RESET  8'h00
// ----------------------------------------
// modes and timing
// ----------------------------------------
`define MODE_SHIFT     2'h0
`define MODE_ASYNC8    2'h1
`define MODE_FIXED9    2'h2
`define MODE_ASYNC9    2'h3
`define SHIFT_DIV      8'h06
`define FIXED_DIV_FAST 8'h10
`define FIXED_DIV_SLOW 8'h20
`define OVERSAMPLE     8'h10
`endif

//--- rtl/serial_bit_timer.v
// bit-rate enable divider
// assumes a divide value of at least one, held stable in a frame
`timescale 1ns/1ps
module serial_bit_timer
(
  // clock and reset
  input  wire       clk_i,
  input  wire       reset_n_i,
  // control
  input  wire       restart_i,
  input  wire [7:0] divide_i,
  // enable out
  output reg        tick_o
);
  reg [7:0] count_q;
  // count down, pulse at zero
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count_q <= 8'h00;
      tick_o  <= 1'b0;
    end
    else if (restart_i || count_q == 8'h00)
    begin
      count_q <= divide_i - 8'h01;
      tick_o  <= !restart_i;
    end
    else
    begin
      count_q <= count_q - 8'h01;
      tick_o  <= 1'b0;
    end
  end
endmodule // serial_bit_timer

//--- rtl/serial_port.v
// serial port: control register, transmitter, receiver, interrupt
// assumes software port on MCLK_I; RXD is asynchronous
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "serial_port_regs.vh"
module serial_port
(
  // clock and reset
  input  wire       MCLK_I,
  input  wire       RESET_N_I,
  // register port
  input  wire [7:0] ADDR_I,
  input  wire [7:0] WDATA_I,
  input  wire       WR_I,
  input  wire       RD_I,
  output reg  [7:0] RDATA_O,
  // serial lines
  input  wire       RXD_I,
  output reg        TXD_O,
  output reg        SCLK_O,
  // interrupt
  output wire       IRQ_O
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [7:0] control_q;
  reg  [7:0] reload_q;
  reg  [7:0] ratectl_q;
  reg  [7:0] rx_data_q;
  reg  [1:0] irq_stat_q;
  reg  [1:0] irq_mask_q;
  reg        rx_s1_q;
  reg        rx_s2_q;
  wire [1:0] mode = control_q[`BIT_MODE_HI:`BIT_MODE_LO];
  wire       wr_ctl = WR_I && ADDR_I == `ADDR_CONTROL;
  wire       wr_data = WR_I && ADDR_I == `ADDR_DATA;
  wire       sw_tx_set = wr_ctl && WDATA_I[`BIT_TXDONE];
  wire       rate_double = ratectl_q[`BIT_DOUBLE];
  // ----------------------------------------
  // bit rate selection
  // ----------------------------------------
  reg  [7:0] divide;
  // one enable per half bit in shift mode, per 1/16 bit otherwise
  always @*
  begin
    case (mode)
      // half-bit enable: the shift clock toggles twice per bit
      `MODE_SHIFT:  divide = `SHIFT_DIV >> 1;
      `MODE_FIXED9: divide = rate_double ? 8'h01 : 8'h02; // doubling gives 1/16
      default:      divide = (reload_q == 8'h00) ? 8'h01 : reload_q;
    endcase
  end
  wire tick;
  serial_bit_timer u_timer
  (
    .clk_i     (MCLK_I),
    .reset_n_i (RESET_N_I),
    .restart_i (wr_ctl || wr_data), // frame starts on a fresh bit phase
    .divide_i  (divide),
    .tick_o    (tick)
  );
  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  reg  [9:0] tx_shift_q;
  reg  [3:0] tx_bits_q;
  reg  [3:0] tx_sub_q;
  reg        tx_busy_q;
  reg        tx_set;
  wire       ninth = (mode == `MODE_FIXED9) || (mode == `MODE_ASYNC9);
  wire [3:0] sub_top = (mode == `MODE_FIXED9) ? 4'hF : 4'hF;
  always @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      tx_shift_q <= 10'h3FF;
      tx_bits_q  <= 4'h0;
      tx_sub_q   <= 4'h0;
      tx_busy_q  <= 1'b0;
      TXD_O      <= 1'b1;
      SCLK_O     <= 1'b1;
    end
    else if (wr_data)
    begin
      // frame: data lsb first, then ninth or stop, then stop
      tx_shift_q <= ninth ? {1'b1, control_q[`BIT_TX9], WDATA_I}
                          : {2'b11, WDATA_I};
      tx_bits_q  <= (mode == `MODE_SHIFT) ? 4'h8 : (ninth ? 4'hB : 4'hA);
      tx_sub_q   <= 4'h0;
      tx_busy_q  <= 1'b1;
      TXD_O      <= (mode == `MODE_SHIFT) ? WDATA_I[0] : 1'b0;
    end
    else if (tx_busy_q && tick)
    begin
      if (mode == `MODE_SHIFT)
      begin
        SCLK_O <= ~SCLK_O;
        if (!SCLK_O)
        begin
          tx_shift_q <= {1'b1, tx_shift_q[9:1]};
          TXD_O      <= tx_shift_q[1];
          tx_bits_q  <= tx_bits_q - 4'h1;
          tx_busy_q  <= tx_bits_q != 4'h1;
        end
      end
      else
      begin
        tx_sub_q <= tx_sub_q + 4'h1;
        if (tx_sub_q == sub_top)
        begin
          TXD_O      <= tx_shift_q[0];
          tx_shift_q <= {1'b1, tx_shift_q[9:1]};
          tx_bits_q  <= tx_bits_q - 4'h1;
          tx_busy_q  <= tx_bits_q != 4'h1;
        end
      end
    end
  end
  // done at 8th bit end (shift) or at start of stop bit
  always @*
  begin
    tx_set = 1'b0;
    if (tx_busy_q && tick)
    begin
      if (mode == `MODE_SHIFT)
        tx_set = !SCLK_O && tx_bits_q == 4'h1;
      else
        tx_set = tx_sub_q == sub_top && tx_bits_q == 4'h2;
    end
  end
  // ----------------------------------------
  // receiver
  // ----------------------------------------
  reg  [9:0] rx_shift_q;
  reg  [3:0] rx_bits_q;
  reg  [3:0] rx_sub_q;
  reg        rx_busy_q;
  reg        rx_done;
  reg        rx_ninth;
  wire       rx_en = control_q[`BIT_RX_EN];
  // two-flop sync of the receive line
  always @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end
    else
    begin
      rx_s1_q <= RXD_I;
      rx_s2_q <= rx_s1_q;
    end
  end
  // asynchronous receive, sampled mid bit
  always @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      rx_shift_q <= 10'h000;
      rx_bits_q  <= 4'h0;
      rx_sub_q   <= 4'h0;
      rx_busy_q  <= 1'b0;
    end
    else if (!rx_busy_q)
    begin
      rx_sub_q  <= 4'h0;
      rx_bits_q <= ninth ? 4'hB : 4'hA;
      rx_busy_q <= rx_en && mode != `MODE_SHIFT && !rx_s2_q;
    end
    else if (tick)
    begin
      rx_sub_q <= rx_sub_q + 4'h1;
      if (rx_sub_q == 4'h7)
      begin
        rx_shift_q <= {rx_s2_q, rx_shift_q[9:1]};
        rx_bits_q  <= rx_bits_q - 4'h1;
        if (rx_bits_q == 4'h1)
          rx_busy_q <= 1'b0;
        else if (rx_bits_q == (ninth ? 4'hB : 4'hA) && rx_s2_q)
          rx_busy_q <= 1'b0; // false start
      end
    end
  end
  // end of frame and the value of the ninth flag
  always @*
  begin
    rx_done  = rx_busy_q && tick && rx_sub_q == 4'h7 && rx_bits_q == 4'h1;
    rx_ninth = ninth ? rx_shift_q[9] : rx_s2_q;
  end
  // ----------------------------------------
  // control register and interrupt state
  // ----------------------------------------
  always @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      control_q  <= `CONTROL_RESET;
      reload_q   <= 8'h00;
      ratectl_q  <= 8'h00;
      rx_data_q  <= 8'h00;
      irq_stat_q <= 2'h0;
      irq_mask_q <= 2'h0;
    end
    else
    begin
      if (wr_ctl)
        control_q <= WDATA_I; // software sets or clears flags
      if (WR_I && ADDR_I == `ADDR_RELOAD)
        reload_q <= WDATA_I;
      if (WR_I && ADDR_I == `ADDR_RATECTL)
        ratectl_q <= WDATA_I;
      if (WR_I && ADDR_I == `ADDR_IRQ_MASK)
        irq_mask_q <= WDATA_I[1:0];
      // hardware set wins over any write
      if (tx_set)
        control_q[`BIT_TXDONE] <= 1'b1;
      if (rx_done)
      begin
        rx_data_q <= ninth ? rx_shift_q[8:1] : rx_shift_q[9:2];
        control_q[`BIT_RXDONE] <= 1'b1;
        if (ninth || !control_q[`BIT_MPCE])
          control_q[`BIT_RX9] <= rx_ninth; // shift mode never here
      end
      irq_stat_q <= (irq_stat_q & ~((WR_I && ADDR_I == `ADDR_IRQ_STAT) ? WDATA_I[1:0] : 2'h0))
                    | {tx_set || sw_tx_set, rx_done};
    end
  end
  assign IRQ_O = |(irq_stat_q & irq_mask_q);
  // read data one cycle after the strobe
  always @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      RDATA_O <= 8'h00;
    else if (RD_I)
    begin
      case (ADDR_I)
        `ADDR_CONTROL:  RDATA_O <= control_q;
        `ADDR_DATA:     RDATA_O <= rx_data_q;
        `ADDR_RELOAD:   RDATA_O <= reload_q;
        `ADDR_RATECTL:  RDATA_O <= ratectl_q;
        `ADDR_IRQ_STAT: RDATA_O <= {6'h00, irq_stat_q};
        `ADDR_IRQ_MASK: RDATA_O <= {6'h00, irq_mask_q};
        default:        RDATA_O <= 8'h00;
      endcase
    end
    else
      RDATA_O <= 8'h00;
  end
endmodule // serial_port

//--- test/serial_port_assertions.sv
// port-level checks of serial_port
// bound from the bench top file; sees only the top ports
`timescale 1ns/1ps
`include "serial_port_regs.vh"
module serial_port_assertions
(
  // ports of serial_port
  input wire       MCLK_I,
  input wire       RESET_N_I,
  input wire [7:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire       WR_I,
  input wire       RD_I,
  input wire [7:0] RDATA_O,
  input wire       RXD_I,
  input wire       TXD_O,
  input wire       SCLK_O,
  input wire       IRQ_O
);
  reg  [7:0] ctl_q;
  wire       asy = ctl_q[7:6] != `MODE_SHIFT;
  // shadow of software control writes
  always @(posedge MCLK_I or negedge RESET_N_I)
    if (!RESET_N_I)
      ctl_q <= 8'h00;
    else if (WR_I && ADDR_I == `ADDR_CONTROL)
      ctl_q <= WDATA_I;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_set; WR_I && ADDR_I == `ADDR_CONTROL && WDATA_I[1]; endsequence
  sequence s_get; RD_I && ADDR_I == `ADDR_CONTROL; endsequence
  property p_idle; $rose(RESET_N_I) |-> TXD_O && SCLK_O; endproperty
  property p_rd0; !$past(RD_I) |-> RDATA_O == 8'h00; endproperty
  property p_unmap; RD_I && ADDR_I == 8'h50 |=> RDATA_O == 8'h00; endproperty
  property p_back; s_get |=> RDATA_O[7:3] == ctl_q[7:3]; endproperty
  property p_set; s_set ##1 !WR_I ##1 s_get |=> RDATA_O[1]; endproperty
  property p_start; WR_I && ADDR_I == `ADDR_DATA && asy |=> !TXD_O [*8]; endproperty
  property p_sclk; asy |-> SCLK_O; endproperty
  property p_mask; WR_I && ADDR_I == `ADDR_IRQ_MASK && WDATA_I == 8'h00 |=> !IRQ_O; endproperty
  a_idle: assert property (p_idle) else $error("lines not idle");
  a_rd0: assert property (p_rd0) else $error("read data outside slot");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_back: assert property (p_back) else $error("control readback wrong");
  a_set: assert property (p_set) else $error("tx flag not set by write");
  a_start: assert property (p_start) else $error("start bit missing");
  a_sclk: assert property (p_sclk) else $error("shift clock moved");
  a_mask: assert property (p_mask) else $error("masked irq high");
endmodule // serial_port_assertions

//--- test/serial_node_model.sv
// remote serial node: decodes TXD frames, drives RXD frames
// assumes bit time in clock cycles from the bench
`timescale 1ns/1ps
module serial_node_model
(
  // clock and control
  input  wire       clk_i,
  input  wire       on_i,
  input  wire [5:0] bit_i,
  // serial lines and decoded frame
  input  wire       txd_i,
  output reg        rxd_o = 1'b1,
  output reg  [8:0] got_o = 9'h000,
  output reg        stb_o = 1'b0
);
  integer i;
  // decode start, nine bits lsb first, mid-bit sampling
  always @(negedge txd_i)
    if (on_i)
    begin
      repeat (bit_i / 2) @(posedge clk_i);
      for (i = 0; i < 9; i = i + 1)
      begin
        repeat (bit_i) @(posedge clk_i);
        got_o[i] = txd_i;
      end
      stb_o <= 1'b1;
      @(posedge clk_i);
      stb_o <= 1'b0;
    end
  // send n bits of f, f[0] first; line rests on the stop level
  task send(input [10:0] f, input integer n);
    integer k;
    for (k = 0; k < n; k = k + 1)
    begin
      rxd_o <= f[k];
      repeat (bit_i) @(posedge clk_i);
    end
  endtask
endmodule // serial_node_model

//--- test/serial_port_tb_top.sv
// bench for serial_port: frames both ways, flags, interrupt
// uses serial_node_model on the serial lines
`timescale 1ns/1ps
`include "serial_port_regs.vh"
module serial_port_tb_top;
  reg         MCLK_I = 1'b0, RESET_N_I = 1'b0, WR_I = 1'b0, RD_I = 1'b0;
  reg  [7:0]  ADDR_I = 8'h00, WDATA_I = 8'h00;
  wire [7:0]  RDATA_O;
  wire        RXD_I, TXD_O, SCLK_O, IRQ_O, stb;
  wire [8:0]  got;
  reg         on = 1'b1, rd_q = 1'b0;
  reg  [7:0]  sh = 8'h00;
  reg  [5:0]  bitc = 6'h10;
  reg  [31:0] seed = 32'hD9E5;
  reg  [17:0] rq[$], fq[$];
  integer     mismatches = 0, n_checks = 0, cyc = 0, m;
  always #12.5 MCLK_I = ~MCLK_I;
  serial_port serial_port_i (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .RXD_I(RXD_I),
    .TXD_O(TXD_O), .SCLK_O(SCLK_O), .IRQ_O(IRQ_O));
  serial_node_model serial_node_model_i (.clk_i(MCLK_I), .on_i(on), .bit_i(bitc),
    .txd_i(TXD_O), .rxd_o(RXD_I), .got_o(got), .stb_o(stb));
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  // compare a value, under mask, against a note {mask, value}
  task chk(input [17:0] n, input [8:0] v);
    n_checks = n_checks + 1;
    if ((v & n[17:9]) !== n[8:0])
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t: got %h want %h", $time, v, n[8:0]);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // bus cycles, one idle edge between strobes
  task wr(input [7:0] a, input [7:0] d);
    @(posedge MCLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge MCLK_I);
    WR_I <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] k, input [7:0] e);
    @(posedge MCLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    rq.push_back({1'b0, k, 1'b0, e});
    @(posedge MCLK_I);
    RD_I <= 1'b0;
  endtask
  // wait for the interrupt, expect it e edges after the write
  task wirq(input integer e);
    integer k;
    k = 0;
    while (IRQ_O !== 1'b1 && k < 800)
    begin
      @(posedge MCLK_I);
      k = k + 1;
    end
    chk({9'h1FF, 9'h001}, {8'h00, k >= e - 1 && k <= e + 1});
    $display("test done at %0t", $time);
  endtask
  // shift-mode data, taken as the shift clock falls mid bit
  always @(negedge SCLK_O)
    sh <= {TXD_O, sh[7:1]};
  // result watcher and timeout
  always @(posedge MCLK_I)
  begin
    rd_q <= RD_I;
    cyc = cyc + 1;
    if (rd_q)
      chk(rq.pop_front(), {1'b0, RDATA_O});
    if (stb)
      chk(fq.pop_front(), got);
    if (cyc == 8000)
    begin
      mismatches = mismatches + 1;
      stop_test;
    end
  end
  initial
  begin
    repeat (6) @(posedge MCLK_I);
    RESET_N_I <= 1'b1;
    rd(`ADDR_CONTROL, 8'hFF, `CONTROL_RESET);
    rd(8'h50, 8'hFF, 8'h00);
    wr(`ADDR_RELOAD, 8'h01);
    wr(`ADDR_IRQ_MASK, 8'h03);
    // transmit in async8, async9, fixed9 fast and slow
    for (m = 0; m < 4; m = m + 1)
    begin
      seed = xs(seed);
      bitc <= (m == 3) ? 6'h20 : 6'h10;
      wr(`ADDR_RATECTL, {7'h00, m != 3});
      wr(`ADDR_CONTROL, {m == 0 ? 2'h1 : m == 1 ? 2'h3 : 2'h2, 2'h1, seed[8], 3'h0});
      fq.push_back({9'h1FF, (m == 0) | seed[8], seed[7:0]});
      wr(`ADDR_DATA, seed[7:0]);
      wirq((m == 0 ? 9 : 10) * bitc + 2);
      repeat (40) @(posedge MCLK_I);
      rd(`ADDR_CONTROL, 8'h02, 8'h02);
      wr(`ADDR_IRQ_MASK, 8'h00);
      wr(`ADDR_IRQ_STAT, 8'h03);
      wr(`ADDR_CONTROL, 8'h10);
      rd(`ADDR_CONTROL, 8'h02, 8'h00);
      wr(`ADDR_IRQ_MASK, 8'h03);
    end
    wr(`ADDR_CONTROL, 8'h12);
    rd(`ADDR_CONTROL, 8'h02, 8'h02);
    rd(`ADDR_IRQ_STAT, 8'h02, 8'h02);
    // receive: stop bit in async8, ninth bit 0 and 1 in async9
    bitc <= 6'h10;
    wr(`ADDR_RATECTL, 8'h00);
    for (m = 0; m < 3; m = m + 1)
    begin
      seed = xs(seed);
      wr(`ADDR_CONTROL, m == 0 ? 8'h50 : 8'hD0);
      serial_node_model_i.send({1'b1, m != 1, seed[7:0], 1'b0}, m == 0 ? 10 : 11);
      repeat (20) @(posedge MCLK_I);
      rd(`ADDR_CONTROL, 8'h05, {5'h00, m != 1, 2'h1});
      rd(`ADDR_DATA, 8'hFF, seed[7:0]);
    end
    // shift mode: ninth flag untouched, tx flag after 8th bit
    wr(`ADDR_CONTROL, 8'h14);
    serial_node_model_i.send({2'h2, seed[7:0], 1'b0}, 11);
    rd(`ADDR_CONTROL, 8'h04, 8'h04);
    on <= 1'b0;
    wr(`ADDR_IRQ_STAT, 8'h03);
    wr(`ADDR_DATA, seed[15:8]);
    wirq(8 * 6 + 2);
    chk({9'h0FF, 1'b0, seed[15:8]}, {1'b0, sh});
    repeat (4) @(posedge MCLK_I);
    stop_test;
  end
endmodule // serial_port_tb_top
bind serial_port serial_port_assertions serial_port_assertions_i (.MCLK_I(MCLK_I),
  .RESET_N_I(RESET_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .RXD_I(RXD_I), .TXD_O(TXD_O), .SCLK_O(SCLK_O), .IRQ_O(IRQ_O));
